// file: dv/sdw_traffic_model.sv
// traffic source: master exchanges and local accesses
// pulses change on the falling edge of core_clk
`timescale 1ns/1ns
`default_nettype none
module sdw_traffic_model (
    input  wire logic core_clk,
    input  wire logic master_on,
    input  wire logic local_on,
    output var  logic master_pd_done = 1'b0,
    output var  logic local_access = 1'b0
);
    logic       master_q = 1'b0;
    logic       local_q = 1'b0;
    logic [1:0] phase = 2'h0;
    // enables taken on the rising edge, away from the bench's falling-edge updates
    always @(posedge core_clk)
    begin
        master_q <= master_on;
        local_q <= local_on;
    end
    always @(negedge core_clk)
    begin
        phase <= phase + 2'h1;
        master_pd_done <= master_q && phase == 2'h0;
        local_access <= local_q && phase == 2'h2;
    end
endmodule // sdw_traffic_model
`default_nettype wire

// file: dv/sdw_watchdog_sva.sv
// assertions on the dual watchdog ports
// bound into every sdw_watchdog instance
`timescale 1ns/1ns
`default_nettype none
module sdw_watchdog_sva (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic        master_pd_done,
    input wire logic        local_access,
    input wire logic [7:0]  app_out,
    input wire logic [7:0]  safe_value,
    input wire logic [2:0]  op_state_in,
    input wire logic [2:0]  op_state_out,
    input wire logic [7:0]  out_drive,
    input wire logic        master_expired,
    input wire logic        local_expired
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_stat_rd; reg_rd && reg_addr == 16'h0440; endsequence
    property p_state; !$past(rst) |-> op_state_out == $past(op_state_in); endproperty
    a_state: assert property (p_state) else $error("state altered");
    property p_drive; !$past(rst) |-> out_drive ==
        ($past(master_expired || local_expired) ? $past(safe_value) : $past(app_out));
    endproperty
    a_drive: assert property (p_drive) else $error("bad drive");
    property p_mclr; master_pd_done |=> !master_expired; endproperty
    a_mclr: assert property (p_mclr) else $error("master not cleared");
    property p_lclr; local_access |=> !local_expired; endproperty
    a_lclr: assert property (p_lclr) else $error("local not cleared");
    property p_stat; s_stat_rd |=> reg_rdata[1:0] == $past({local_expired, master_expired});
    endproperty
    a_stat: assert property (p_stat) else $error("bad status");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_mrise; $rose(master_expired) |-> !$past(master_pd_done); endproperty
    a_mrise: assert property (p_mrise) else $error("trip on traffic");
    property p_mfall; $fell(master_expired) |-> $past(master_pd_done) ||
        ($past(reg_wr, 2) && $past(reg_addr, 2) == 16'h0420); endproperty
    a_mfall: assert property (p_mfall) else $error("trip lost");
endmodule // sdw_watchdog_sva
bind sdw_watchdog sdw_watchdog_sva i_sva (.*);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the dual watchdog
// drives inputs on the falling edge of a 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        master_on = 1'b0, local_on = 1'b0, master_pd_done, local_access;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
    logic [7:0]  app_out = 8'ha5, safe_value = 8'h3c, out_drive;
    logic [2:0]  op_state_in = 3'h5, op_state_out;
    logic        master_expired, local_expired;
    int          fails = 0, checks = 0, cycles = 0;
    initial forever #25 core_clk = ~core_clk;
    sdw_traffic_model i_model (.*);
    sdw_watchdog i_dut (.*);
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check("rdata", exp, reg_rdata);
    endtask
    task automatic wait_flags(input int n, input logic [1:0] exp);
        repeat (n) @(negedge core_clk);
        check("flags", {14'h0, exp}, {14'h0, local_expired, master_expired});
    endtask
    task final_report;
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            final_report();
        end
    end
    initial
    begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        rd(16'h0400, 16'h09c2);
        rd(16'h0420, 16'h03e8);
        rd(16'h0410, 16'h03e8);
        rd(16'h0404, 16'h0000);
        master_on = 1'b1;
        local_on = 1'b1;
        wr(16'h0400, 16'h000a);
        wr(16'h0420, 16'h0002);
        wr(16'h0410, 16'h0002);
        rd(16'h0400, 16'h000a);
        rd(16'h0410, 16'h0002);
        wait_flags(40, 2'b00);
        master_on = 1'b0;
        // a tick is 12 base ticks; trip comes 2 to 3 ticks after the last exchange
        wait_flags(12, 2'b00);
        wait_flags(30, 2'b01);
        check("drive", 16'h003c, {8'h00, out_drive});
        check("state", 16'h0005, {13'h0, op_state_out});
        rd(16'h0440, 16'h0001);
        master_on = 1'b1;
        wait_flags(8, 2'b00);
        check("drive", 16'h00a5, {8'h00, out_drive});
        local_on = 1'b0;
        wait_flags(50, 2'b10);
        check("drive", 16'h003c, {8'h00, out_drive});
        local_on = 1'b1;
        wr(16'h0420, 16'h0000);
        master_on = 1'b0;
        wait_flags(60, 2'b00);
        check("drive", 16'h00a5, {8'h00, out_drive});
        final_report();
    end
endmodule // tb_top
`default_nettype wire

// file: logic/sdw_defines.vh
// constants for the dual communication watchdog block
// assumes a 20 MHz core clock and 16-bit register access by the slave controller core
`ifndef SDW_DEFINES_VH
`define SDW_DEFINES_VH

`define SDW_ADDR_MULT        16'h0400
`define SDW_ADDR_LOCAL_CNT   16'h0410
`define SDW_ADDR_MASTER_CNT  16'h0420
`define SDW_ADDR_STATUS      16'h0440

`define SDW_MULT_RESET       16'h09c2
`define SDW_MASTER_RESET     16'h03e8
`define SDW_LOCAL_RESET      16'h03e8

`define SDW_STAT_MASTER_BIT  0
`define SDW_STAT_LOCAL_BIT   1

// base tick is 40 ns, made from the 20 MHz core clock by a phase accumulator
`define SDW_BASE_TICK_NS     7'h28
`define SDW_TWO_TICK_NS      7'h50
`define SDW_CORE_PERIOD_NS   7'h32
// accumulator adds the core period and wraps at the base tick
`define SDW_ACC_W            7

`endif

// file: logic/sdw_watchdog.v
// dual communication watchdog: master traffic and local process interface
// assumes register strobes and traffic events are one-cycle pulses on core_clk
// the 50 ns core period advances a 40 ns base time by one or two base ticks per cycle
// both watchdogs share the prescaler but reload and trip independently
// a multiplier or count written mid-run takes effect at the next tick or restart
// Behaviour
// (RULE1) two independent watchdogs, one per traffic source, each defaulting to 100 ms.
// (RULE2) one multiplier register sets the tick prescale of both watchdogs.
// (RULE3) master traffic count sits at 420h and local interface count at 410h.
// (RULE4) a watchdog tick is multiplier plus two base ticks of 40 ns; timeout is tick times count.
// (RULE5) reset values are multiplier 2498 and master count 1000, giving 100 ms.
// (RULE6) each completed process data exchange with the master restarts its countdown.
// (RULE7) the master watchdog trips when enabled and no exchange occurs within the timeout.
// (RULE8) tripping the master watchdog leaves the operating state untouched.
// (RULE9) a tripped master watchdog stays tripped until the next successful exchange.
// (RULE10) the local watchdog trips when enabled and the local interface is idle past its timeout.
// (RULE11) a tripped watchdog drives the outputs to the preset safe state.
// (RULE12) a master count of zero disables that watchdog and never forces the safe state.
// (RULE13) the master writes these settings at startup only when their download is enabled.
// (RULE14) without a download the register contents stay as they were.
// (RULE15) the multiplier and both counts read back from register space.
// (RULE16) the timeout reaches about 170 seconds with the full 16-bit settings.
// (RULE17) each watchdog has a readable expired flag cleared by its own restart event.
`timescale 1ns/1ns
`default_nettype none
`include "sdw_defines.vh"

module sdw_watchdog (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    input  wire        master_pd_done,
    input  wire        local_access,
    input  wire [7:0]  app_out,
    input  wire [7:0]  safe_value,
    input  wire [2:0]  op_state_in,
    output reg  [2:0]  op_state_out,
    output reg  [7:0]  out_drive,
    output reg         master_expired,
    output reg         local_expired
);

    // configuration registers
    reg  [15:0]              mult;
    reg  [15:0]              master_count;
    reg  [15:0]              local_count;
    reg  [15:0]              next_mult;
    reg  [15:0]              next_master_count;
    reg  [15:0]              next_local_count;
    reg  [15:0]              next_reg_rdata;
    wire                     hit_mult;
    wire                     hit_master;
    wire                     hit_local;
    wire                     hit_status;

    // base time accumulator and shared prescale
    reg  [`SDW_ACC_W-1:0]    base_acc;
    reg  [1:0]               base_step;
    reg  [16:0]              pre_cnt;
    reg                      wd_tick;
    reg  [`SDW_ACC_W-1:0]    next_base_acc;
    reg  [1:0]               next_base_step;
    reg  [16:0]              next_pre_cnt;
    reg                      next_wd_tick;
    wire [`SDW_ACC_W-1:0]    acc_sum;
    wire [16:0]              pre_sum;
    wire [16:0]              tick_len;

    // watchdog countdowns
    reg  [15:0]              master_left;
    reg  [15:0]              local_left;
    reg  [15:0]              next_master_left;
    reg  [15:0]              next_local_left;
    reg                      next_master_expired;
    reg                      next_local_expired;
    wire                     master_en;
    wire                     local_en;
    wire                     master_restart;
    wire                     local_restart;

    // output stage
    reg  [7:0]               next_out_drive;
    wire                     any_expired;

    function sel;
        input [15:0] a;
        input [15:0] b;
        begin
            sel = (a == b);
        end
    endfunction

    // one countdown step: bit 16 is the next expired flag, bits 15:0 the next count
    function [16:0] wd_step;
        input        restart;
        input        tick;
        input        expired;
        input [15:0] left;
        input [15:0] reload;
        begin
            // restart wins over a trip in the same cycle
            if (restart)
                wd_step = {1'b0, reload};
            // (RULE9) tripped state holds
            else if (!tick || expired)
                wd_step = {expired, left};
            else if (left == 16'h0000)
                wd_step = {1'b1, 16'h0000};
            else
                wd_step = {1'b0, left - 16'h0001};
        end
    endfunction

    // address decode
    assign hit_mult   = sel(reg_addr, `SDW_ADDR_MULT);
    // (RULE3) separate count registers
    assign hit_master = sel(reg_addr, `SDW_ADDR_MASTER_CNT);
    assign hit_local  = sel(reg_addr, `SDW_ADDR_LOCAL_CNT);
    assign hit_status = sel(reg_addr, `SDW_ADDR_STATUS);

    // (RULE2) shared prescale
    assign tick_len = {1'b0, mult} + 17'h0_0002;
    // (RULE4) 40 ns base time
    assign acc_sum  = base_acc + `SDW_CORE_PERIOD_NS;
    assign pre_sum  = pre_cnt + {15'h0000, base_step};
    // (RULE12) zero count disables
    assign master_en = (master_count != 16'h0000);
    assign local_en  = (local_count != 16'h0000);
    // (RULE6) restart on exchange
    assign master_restart = master_pd_done || !master_en;
    // (RULE17) own restart clears
    assign local_restart  = local_access || !local_en;
    assign any_expired    = master_expired || local_expired;

    // (RULE14) untouched unless written
    always @*
    begin
        next_mult         = mult;
        next_master_count = master_count;
        next_local_count  = local_count;
        if (reg_wr && hit_mult)
            next_mult = reg_wdata;
        if (reg_wr && hit_master)
            next_master_count = reg_wdata;
        if (reg_wr && hit_local)
            next_local_count = reg_wdata;
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            // (RULE5) default settings
            mult         <= `SDW_MULT_RESET;
            master_count <= `SDW_MASTER_RESET;
            // (RULE1) local default 100 ms
            local_count  <= `SDW_LOCAL_RESET;
        end
        else
        begin
            mult         <= next_mult;
            master_count <= next_master_count;
            local_count  <= next_local_count;
        end
    end

    // (RULE15) read back, unmapped reads zero
    always @*
    begin
        next_reg_rdata = reg_rdata;
        if (reg_rd)
        begin
            next_reg_rdata = 16'h0000;
            if (hit_mult)
                next_reg_rdata = mult;
            if (hit_master)
                next_reg_rdata = master_count;
            if (hit_local)
                next_reg_rdata = local_count;
            // (RULE17) expired flags readable
            if (hit_status)
                next_reg_rdata = {14'h0000, local_expired, master_expired};
        end
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= next_reg_rdata;
    end

    // (RULE4) base ticks and prescale
    always @*
    begin
        next_base_acc  = acc_sum - `SDW_BASE_TICK_NS;
        next_base_step = 2'h1;
        if (acc_sum >= `SDW_TWO_TICK_NS)
        begin
            next_base_acc  = acc_sum - `SDW_TWO_TICK_NS;
            next_base_step = 2'h2;
        end
        next_pre_cnt = pre_sum;
        next_wd_tick = 1'b0;
        if (pre_sum >= tick_len)
        begin
            next_wd_tick = 1'b1;
            next_pre_cnt = pre_sum - tick_len;
            // a shortened multiplier must not release a burst of ticks
            if (next_pre_cnt >= tick_len)
                next_pre_cnt = 17'h0_0000;
        end
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            base_acc  <= {`SDW_ACC_W{1'b0}};
            base_step <= 2'h0;
            pre_cnt   <= 17'h0_0000;
            wd_tick   <= 1'b0;
        end
        else
        begin
            base_acc  <= next_base_acc;
            base_step <= next_base_step;
            pre_cnt   <= next_pre_cnt;
            wd_tick   <= next_wd_tick;
        end
    end

    // (RULE7) trip past timeout
    always @*
    begin
        {next_master_expired, next_master_left} =
            wd_step(master_restart, wd_tick, master_expired, master_left, master_count);
    end

    // (RULE10) local idle timeout
    always @*
    begin
        {next_local_expired, next_local_left} =
            wd_step(local_restart, wd_tick, local_expired, local_left, local_count);
    end

    // (RULE16) 16-bit counts, ~170 s
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            master_left    <= `SDW_MASTER_RESET;
            master_expired <= 1'b0;
        end
        else
        begin
            master_left    <= next_master_left;
            master_expired <= next_master_expired;
        end
    end

    // local countdown registers
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            local_left    <= `SDW_LOCAL_RESET;
            local_expired <= 1'b0;
        end
        else
        begin
            local_left    <= next_local_left;
            local_expired <= next_local_expired;
        end
    end

    // (RULE11) safe state on expiry
    always @*
    begin
        next_out_drive = app_out;
        if (any_expired)
            next_out_drive = safe_value;
    end

    // output drive register
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            out_drive <= 8'h00;
        else
            out_drive <= next_out_drive;
    end

    // (RULE8) state unaffected
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            op_state_out <= 3'h0;
        else
            op_state_out <= op_state_in;
    end

endmodule // sdw_watchdog
`default_nettype wire
